// file: verilog/gif_input_filter.sv
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "gif_params.svh"

module gif_input_filter #(
    parameter logic [`GIF_ACC_W-1:0] TICK_NUM  = `GIF_ACC_W'(`GIF_FILT_MHZ),
    parameter logic [`GIF_ACC_W-1:0] TICK_DEN  = `GIF_ACC_W'(`GIF_CLK_MHZ),
    parameter logic [`GIF_CNT_W-1:0] SPAN_BASE = `GIF_CNT_W'(`GIF_SPAN_BASE)
) (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    // Avalon-MM slave
    input  wire gif_pkg::gif_avs_req_t avs_req_in,
    output logic [31:0]                avs_readdata_out,
    output logic                       avs_waitrequest_out,
    // field inputs and their filtered values
    input  wire logic [31:0]           field_in,
    output logic [31:0]                filtered_out
);
    import gif_pkg::*;

    gif_top_st_t                  q;
    gif_top_st_t                  next_q;
    logic                         tick;
    logic                         req;
    logic                         stall;
    logic                         go;
    logic                         busy;
    logic [`GIF_NIBBLES-1:0]      nib_en;
    logic [`GIF_TC_W-1:0]         nib_code [`GIF_NIBBLES];
    logic [`GIF_LINES-1:0]        flt;

    // time constant code chosen by a 2-bit nibble selection
    function automatic logic [`GIF_TC_W-1:0] tc_of(
        input logic [1:0]  sel,
        input logic [11:0] tcs
    );
        logic [`GIF_TC_W-1:0] code;
        code = tcs[3:0];
        case (sel)
            2'h2:    code = tcs[7:4];
            2'h3:    code = tcs[11:8];
            default: code = tcs[3:0];
        endcase
        return code;
    endfunction

    gif_tick_gen #(
        .TICK_NUM (TICK_NUM),
        .TICK_DEN (TICK_DEN)
    ) u_tick (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .tick_out (tick)
    );

    // per-nibble enable and code
    always_comb begin
        for (int n = 0; n < `GIF_NIBBLES; n++) begin
            nib_en[n]   = q.filt_sel[2*n +: 2] != `GIF_SEL_NONE;
            nib_code[n] = tc_of(q.filt_sel[2*n +: 2], q.tc);
        end
    end

    for (genvar i = 0; i < `GIF_LINES; i++) begin : g_line
        gif_integrator #(
            .SPAN_BASE (SPAN_BASE)
        ) u_int (
            .clk_in       (clk_in),
            .rst_n_in     (rst_n_in),
            .tick_in      (tick),
            .enable_in    (nib_en[i/4]),
            .code_in      (nib_code[i/4]),
            .raw_in       (field_in[i]),
            .filtered_out (flt[i])
        );
    end

    assign busy  = q.state != GIF_IDLE;
    assign req   = avs_req_in.read | avs_req_in.write;
    // a new command waits until the previous one has finished
    assign stall = avs_req_in.write && busy
                   && (avs_req_in.address == `GIF_OFS_CMD);
    assign go    = req & q.ack;

    always_comb begin
        next_q     = q;
        next_q.ack = 1'b0;

        // command sequencer: taken, executed, applied
        case (q.state)
            GIF_IDLE: begin
                next_q.state = GIF_IDLE;
            end
            GIF_EXEC: begin
                next_q.state = GIF_APPLY;
            end
            GIF_APPLY: begin
                next_q.state = GIF_IDLE;
                case (q.cmd)
                    `GIF_CMD_SEL_WR: begin
                        next_q.filt_sel = {q.data_hi, q.data_lo};
                    end
                    `GIF_CMD_TC_WR: begin
                        next_q.tc = {q.data_hi[3:0], q.data_lo};
                    end
                    `GIF_CMD_SEL_RD: begin
                        next_q.rd_lo = q.filt_sel[7:0];
                        next_q.rd_hi = q.filt_sel[15:8];
                    end
                    `GIF_CMD_TC_RD: begin
                        next_q.rd_lo = q.tc[7:0];
                        next_q.rd_hi = {4'h0, q.tc[11:8]};
                    end
                    default: begin
                        next_q.rd_lo = q.rd_lo;
                    end
                endcase
            end
            default: begin
                next_q.state = GIF_IDLE;
            end
        endcase

        // one wait cycle, then read data stand in a register
        if (req && !q.ack && !stall) begin
            next_q.ack = 1'b1;
            case (avs_req_in.address)
                `GIF_OFS_READ_LO: next_q.readdata = {24'h0, q.rd_lo};
                `GIF_OFS_READ_HI: next_q.readdata = {24'h0, q.rd_hi};
                `GIF_OFS_STATUS:  next_q.readdata = {31'h0, busy};
                `GIF_OFS_INPUTS:  next_q.readdata = q.inputs;
                default:          next_q.readdata = 32'h0;
            endcase
        end

        // writes take effect at the edge where waitrequest is low
        if (go && avs_req_in.write && avs_req_in.byteenable[0]) begin
            case (avs_req_in.address)
                `GIF_OFS_CMD: begin
                    next_q.cmd   = avs_req_in.writedata[7:0];
                    next_q.state = GIF_EXEC;
                end
                `GIF_OFS_DATA_LO: begin
                    next_q.data_lo = avs_req_in.writedata[7:0];
                end
                `GIF_OFS_DATA_HI: begin
                    next_q.data_hi = avs_req_in.writedata[7:0];
                end
                default: begin
                    next_q.cmd = q.cmd;
                end
            endcase
        end

        // bypassed nibbles pass the raw input
        for (int b = 0; b < `GIF_LINES; b++) begin
            next_q.inputs[b] = nib_en[b/4] ? flt[b] : field_in[b];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q          <= '0;
            q.state    <= GIF_IDLE;
            q.filt_sel <= `GIF_SEL_RST;
            q.tc       <= `GIF_TC_RST;
        end else begin
            q <= next_q;
        end
    end

    assign avs_waitrequest_out = req & ~q.ack;
    assign avs_readdata_out    = q.readdata;
    assign filtered_out        = q.inputs;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_cmd_taken;
        go && avs_req_in.write && avs_req_in.byteenable[0]
           && (avs_req_in.address == `GIF_OFS_CMD);
    endsequence

    sequence s_cmd_run;
        (q.state == GIF_EXEC) ##1 (q.state == GIF_APPLY)
            ##1 (q.state == GIF_IDLE);
    endsequence

    property p_cmd_run;
        s_cmd_taken |=> s_cmd_run;
    endproperty
    a_cmd_run: assert property (p_cmd_run)
        else $error("command did not run in two cycles");

    property p_sel_apply;
        (q.state == GIF_APPLY && q.cmd == `GIF_CMD_SEL_WR)
            |=> q.filt_sel == $past({q.data_hi, q.data_lo});
    endproperty
    a_sel_apply: assert property (p_sel_apply)
        else $error("filter choice not loaded");

    property p_tc_apply;
        (q.state == GIF_APPLY && q.cmd == `GIF_CMD_TC_WR)
            |=> q.tc == $past({q.data_hi[3:0], q.data_lo});
    endproperty
    a_tc_apply: assert property (p_tc_apply)
        else $error("time constants not loaded");

    property p_sel_read;
        (q.state == GIF_APPLY && q.cmd == `GIF_CMD_SEL_RD)
            |=> q.rd_lo == $past(q.filt_sel[7:0])
                && q.rd_hi == $past(q.filt_sel[15:8]);
    endproperty
    a_sel_read: assert property (p_sel_read)
        else $error("filter choice readback wrong");

    property p_reset_clear;
        $rose(rst_n_in) |-> q.filt_sel == `GIF_SEL_RST
                            && q.tc == `GIF_TC_RST;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("settings not cleared by reset");

    property p_bypass;
        (q.filt_sel[1:0] == `GIF_SEL_NONE)
            |=> filtered_out[0] == $past(field_in[0]);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypassed line does not follow input");

    property p_status_read;
        (avs_req_in.read && !avs_waitrequest_out
         && avs_req_in.address == `GIF_OFS_STATUS)
            |-> avs_readdata_out[`GIF_STATUS_BUSY_BIT] == $past(busy);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("busy status read wrong");

endmodule
`default_nettype wire

// file: shared/gif_params.svh
`ifndef GIF_PARAMS_SVH
`define GIF_PARAMS_SVH

// register byte offsets on the Avalon-MM slave
`define GIF_ADDR_W          5
`define GIF_OFS_CMD         5'h00
`define GIF_OFS_DATA_LO     5'h04
`define GIF_OFS_DATA_HI     5'h08
`define GIF_OFS_READ_LO     5'h0C
`define GIF_OFS_READ_HI     5'h10
`define GIF_OFS_STATUS      5'h14
`define GIF_OFS_INPUTS      5'h18
`define GIF_STATUS_BUSY_BIT 0

// command codes
`define GIF_CMD_SEL_WR      8'hC1
`define GIF_CMD_TC_WR       8'hC2
`define GIF_CMD_SEL_RD      8'hD1
`define GIF_CMD_TC_RD       8'hD2

// field layout and reset values
`define GIF_SEL_NONE        2'h0
`define GIF_SEL_RST         16'h0000
`define GIF_TC_RST          12'h000
`define GIF_TC_W            4
`define GIF_LINES           32
`define GIF_NIBBLES         8

// timing
`define GIF_CLK_MHZ         250
`define GIF_FILT_MHZ        16
`define GIF_NOM_DELAY0_NS   1000
`define GIF_SPAN_BASE       ((`GIF_NOM_DELAY0_NS * `GIF_FILT_MHZ) / 1000)
`define GIF_CNT_W           20
`define GIF_ACC_W           9

`endif

// file: shared/gif_pkg.sv
package gif_pkg;
`include "gif_params.svh"

typedef enum logic [2:0] {
    GIF_IDLE  = 3'h1,
    GIF_EXEC  = 3'h2,
    GIF_APPLY = 3'h4
} gif_cmd_st_t;

typedef struct packed {
    logic                   read;
    logic                   write;
    logic [`GIF_ADDR_W-1:0] address;
    logic [31:0]            writedata;
    logic [3:0]             byteenable;
} gif_avs_req_t;

typedef struct packed {
    logic [`GIF_ACC_W-1:0] acc;
    logic                  tick;
} gif_tick_st_t;

typedef struct packed {
    logic [`GIF_CNT_W-1:0] cnt;
    logic                  flt;
} gif_int_st_t;

typedef struct packed {
    gif_cmd_st_t state;
    logic [7:0]  cmd;
    logic [7:0]  data_lo;
    logic [7:0]  data_hi;
    logic [7:0]  rd_lo;
    logic [7:0]  rd_hi;
    logic [15:0] filt_sel;
    logic [11:0] tc;
    logic        ack;
    logic [31:0] readdata;
    logic [31:0] inputs;
} gif_top_st_t;

endpackage

// file: verilog/gif_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "gif_params.svh"

module gif_tick_gen #(
    parameter logic [`GIF_ACC_W-1:0] TICK_NUM = `GIF_ACC_W'(`GIF_FILT_MHZ),
    parameter logic [`GIF_ACC_W-1:0] TICK_DEN = `GIF_ACC_W'(`GIF_CLK_MHZ)
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // filter time base enable
    output logic      tick_out
);
    import gif_pkg::*;

    gif_tick_st_t q;
    gif_tick_st_t next_q;

    // fractional divider: average tick rate is clk * NUM / DEN
    always_comb begin
        next_q      = q;
        next_q.tick = 1'b0;
        next_q.acc  = q.acc + TICK_NUM;
        if (next_q.acc >= TICK_DEN) begin
            next_q.acc  = next_q.acc - TICK_DEN;
            next_q.tick = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tick_out = q.tick;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_acc_range;
        q.tick |-> (q.acc < TICK_DEN) ##1 (q.acc < TICK_DEN);
    endproperty
    a_acc_range: assert property (p_acc_range)
        else $error("tick accumulator out of range");

endmodule
`default_nettype wire

// file: verilog/gif_integrator.sv
`timescale 1ns/1ns
`default_nettype none
`include "gif_params.svh"

module gif_integrator #(
    parameter logic [`GIF_CNT_W-1:0] SPAN_BASE = `GIF_CNT_W'(`GIF_SPAN_BASE)
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // control
    input  wire logic                 tick_in,
    input  wire logic                 enable_in,
    input  wire logic [`GIF_TC_W-1:0] code_in,
    // signal
    input  wire logic                 raw_in,
    output logic                      filtered_out
);
    import gif_pkg::*;

    gif_int_st_t           q;
    gif_int_st_t           next_q;
    logic [`GIF_CNT_W-1:0] span;

    assign span = SPAN_BASE << code_in;

    always_comb begin
        next_q = q;
        // disabled: counter and held output stay frozen
        if (enable_in) begin
            if (tick_in) begin
                if (raw_in && (q.cnt < span)) begin
                    next_q.cnt = q.cnt + 1'b1;
                end else if (!raw_in && (q.cnt != '0)) begin
                    next_q.cnt = q.cnt - 1'b1;
                end
            end
            // a shorter code takes effect at once
            if (next_q.cnt > span) begin
                next_q.cnt = span;
            end
            // output moves only at saturation
            if (next_q.cnt == span) begin
                next_q.flt = 1'b1;
            end else if (next_q.cnt == '0) begin
                next_q.flt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign filtered_out = q.flt;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_rise_at_sat;
        $rose(q.flt) |-> (q.cnt == $past(span));
    endproperty
    a_rise_at_sat: assert property (p_rise_at_sat)
        else $error("filter output rose before saturation");

    property p_frozen;
        !enable_in |=> $stable(q.cnt) && $stable(q.flt);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("integrator moved while unfiltered");

    property p_fall_at_zero;
        $fell(q.flt) |-> (q.cnt == '0);
    endproperty
    a_fall_at_zero: assert property (p_fall_at_zero)
        else $error("filter output fell before reaching zero");

endmodule
`default_nettype wire

// file: sim/gif_field_src.sv
`timescale 1ns/1ns
`default_nettype none

module gif_field_src (
    // clock
    input  wire logic        clk_in,
    // field lines
    output logic      [31:0] field_out
);
    initial field_out = 32'h0000_0000;

    // lines change just after the edge, like a synchronised source
    task automatic drive(input logic [31:0] v);
        @(posedge clk_in);
        field_out <= v;
    endtask

    // one isolated pulse of w clocks, then the old level again
    task automatic glitch(input logic [31:0] v, input int w);
        logic [31:0] old;
        old = field_out;
        drive(v);
        repeat (w) @(posedge clk_in);
        field_out <= old;
    endtask
endmodule

`default_nettype wire

// file: sim/test_gif_input_filter.sv
`timescale 1ns/1ns
`default_nettype none
`include "gif_params.svh"

module test_gif_input_filter;
    import gif_pkg::*;
    logic         clk_in;
    logic         rst_n_in;
    gif_avs_req_t req;
    logic  [31:0] rdata;
    logic         wreq;
    logic  [31:0] fld;
    logic  [31:0] filt;
    logic  [31:0] v;
    logic  [15:0] sel;
    logic  [1:0]  s;
    int           err_total;
    int           total_checks;
    int           cyc;
    int           d;
    int           sp;
    int           tcs[4];

    // one tick per clock and a span of two ticks at code 0
    gif_input_filter #(
        .TICK_NUM (9'h001),
        .TICK_DEN (9'h001),
        .SPAN_BASE(20'h00002)
    ) gif_input_filter_i (
        .clk_in             (clk_in),
        .rst_n_in           (rst_n_in),
        .avs_req_in         (req),
        .avs_readdata_out   (rdata),
        .avs_waitrequest_out(wreq),
        .field_in           (fld),
        .filtered_out       (filt)
    );

    gif_field_src gif_field_src_i (
        .clk_in   (clk_in),
        .field_out(fld)
    );

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            complete_run;
        end
    end

    task automatic check(input string nm, input logic [31:0] sn,
                         input logic [31:0] ex);
        total_checks = total_checks + 1;
        if (sn !== ex) begin
            err_total = err_total + 1;
            $display("BAD %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    // request stands until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] wd, output logic [31:0] rd);
        @(posedge clk_in);
        req <= '{read: ~wr, write: wr, address: a,
                 writedata: {24'h000000, wd}, byteenable: 4'hF};
        do begin
            @(posedge clk_in);
        end while (wreq !== 1'b0);
        rd = rdata;
        req <= '0;
    endtask

    task automatic cmd(input logic [7:0] c, input logic [7:0] lo,
                       input logic [7:0] hi);
        logic [31:0] dummy;
        bus(1'b1, `GIF_OFS_DATA_LO, lo, dummy);
        bus(1'b1, `GIF_OFS_DATA_HI, hi, dummy);
        bus(1'b1, `GIF_OFS_CMD, c, dummy);
        repeat (3) @(posedge clk_in);
    endtask

    task automatic rb(input logic [7:0] c, input logic [15:0] e);
        logic [31:0] r;
        cmd(c, 8'h00, 8'h00);
        bus(1'b0, `GIF_OFS_READ_LO, 8'h00, r);
        check("read_lo", r, {24'h000000, e[7:0]});
        bus(1'b0, `GIF_OFS_READ_HI, 8'h00, r);
        check("read_hi", r, {24'h000000, e[15:8]});
    endtask

    task automatic wnib(input int n, input logic [3:0] e, input int lim,
                        output int c);
        c = 0;
        do begin
            @(negedge clk_in);
            c = c + 1;
        end while (filt[4*n+:4] !== e && c < lim);
    endtask

    initial begin
        rst_n_in = 1'b0;
        req = '0;
        err_total = 0;
        total_checks = 0;
        cyc = 0;
        tcs = '{0, 0, 3, 5};
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rb(`GIF_CMD_SEL_RD, 16'h0000);
        rb(`GIF_CMD_TC_RD, 16'h0000);
        bus(1'b0, 5'h1C, 8'h00, v);
        check("unmapped", v, 32'h0000_0000);
        bus(1'b0, `GIF_OFS_DATA_LO, 8'h00, v);
        check("write_only", v, 32'h0000_0000);
        // every nibble passes straight through after reset
        gif_field_src_i.drive(32'hA5C3_0F96);
        repeat (3) @(posedge clk_in);
        check("bypass", filt, 32'hA5C3_0F96);
        bus(1'b0, `GIF_OFS_INPUTS, 8'h00, v);
        check("inputs", v, 32'hA5C3_0F96);
        gif_field_src_i.drive(32'h0000_0000);
        cmd(`GIF_CMD_TC_WR, 8'hF7, 8'hAE);
        rb(`GIF_CMD_TC_RD, 16'h0EF7);
        // codes suited to line receivers and fast couplers
        cmd(`GIF_CMD_TC_WR, 8'h30, 8'hF5);
        // a code with no function here changes nothing
        cmd(8'hE0, 8'hFF, 8'hFF);
        rb(`GIF_CMD_TC_RD, 16'h0530);
        bus(1'b0, `GIF_OFS_STATUS, 8'h00, v);
        check("status", v, 32'h0000_0000);
        sel = 16'h1BE4;
        // every nibble is an input here, so any choice is allowed
        cmd(`GIF_CMD_SEL_WR, sel[7:0], sel[15:8]);
        rb(`GIF_CMD_SEL_RD, sel);
        // step each nibble and time its output
        v = 32'h0000_0000;
        for (int n = 0; n < 8; n++) begin
            s = sel[2*n+:2];
            sp = 2 << tcs[s];
            v[4*n+:4] = 4'hF;
            gif_field_src_i.drive(v);
            wnib(n, 4'hF, 200, d);
            check("step", {31'h0, (s == 2'h0) ? (d <= 2) :
                  (d * 8 >= sp * 7 && d <= sp + 20)}, 32'h1);
        end
        // short pulses vanish on filtered nibbles
        for (int n = 0; n < 8; n++) begin
            s = sel[2*n+:2];
            sp = 2 << tcs[s];
            if (s != 2'h0) begin
                gif_field_src_i.glitch(v & ~(32'hF << (4 * n)), sp * 7 / 8);
                wnib(n, 4'h0, sp + 30, d);
                check("glitch", {28'h0, filt[4*n+:4]}, 32'hF);
            end
        end
        // bypass nibble 3, drop its input, then filter it again
        cmd(`GIF_CMD_SEL_WR, 8'h24, sel[15:8]);
        v[15:12] = 4'h0;
        gif_field_src_i.drive(v);
        wnib(3, 4'h0, 10, d);
        check("unfiltered", {31'h0, d <= 2}, 32'h1);
        repeat (100) @(posedge clk_in);
        cmd(`GIF_CMD_SEL_WR, sel[7:0], sel[15:8]);
        // the new choice reaches the output register one clock later
        @(negedge clk_in);
        check("held", {28'h0, filt[15:12]}, 32'hF);
        wnib(3, 4'h0, 200, d);
        check("refresh", {31'h0, d <= 84}, 32'h1);
        // a second reset in mid-run clears every setting again
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rb(`GIF_CMD_SEL_RD, 16'h0000);
        rb(`GIF_CMD_TC_RD, 16'h0000);
        complete_run;
    end
endmodule

`default_nettype wire
